// >>> pkg/ldo_regs_cfg.svh
/*
  Constants for the linear-regulator control register bank: register
  indices, byte-address scaling, field positions, writable masks, reset
  values and voltage-code conversion figures.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef LDO_REGS_CFG_SVH
`define LDO_REGS_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IDX_REG5_ON_CTRL      16'h4075
`define IDX_REG5_SLEEP_CTRL   16'h4076
`define IDX_REG6_MAIN_CTRL    16'h4077
`define IDX_REG6_ON_CTRL      16'h4078
`define IDX_REG6_SLEEP_CTRL   16'h4079
`define IDX_REG7_MAIN_CTRL    16'h407A
`define IDX_REG7_ON_CTRL      16'h407B
`define IDX_IRQ_STATUS        16'h40F0
`define IDX_IRQ_CLEAR         16'h40F1
`define IDX_IRQ_ENABLE        16'h40F2

// storage slots of the control array
`define SLOT_REG5_ON          3'h0
`define SLOT_REG5_SLEEP       3'h1
`define SLOT_REG6_MAIN        3'h2
`define SLOT_REG6_ON          3'h3
`define SLOT_REG6_SLEEP       3'h4
`define SLOT_REG7_MAIN        3'h5
`define SLOT_REG7_ON          3'h6
`define CTRL_COUNT            7

// on / sleep control fields
`define FLD_SLOT_HI           15
`define FLD_SLOT_LO           13
`define FLD_MODE              8
`define FLD_VCODE_HI          4
`define FLD_VCODE_LO          0

// main control fields
`define FLD_ERR_ACT_HI        15
`define FLD_ERR_ACT_LO        14
`define FLD_HW_SRC_HI         12
`define FLD_HW_SRC_LO         11
`define FLD_HW_VPICK          10
`define FLD_HW_MODE_HI        9
`define FLD_HW_MODE_LO        8
`define FLD_FLOAT             7
`define FLD_SWITCH            6
`define FLD_LP_VARIANT        0

// writable bits; everything else reads zero
`define MASK_ONSLEEP_CTRL     16'hE11F
`define MASK_REG6_MAIN        16'hDFC1
`define MASK_REG7_MAIN        16'hDFC0

`define RESET_ON_CTRL         16'h0000
`define RESET_SLEEP_CTRL      16'h0100
`define RESET_MAIN_CTRL       16'h0200
`define RESET_IRQ             3'h0

// undervoltage action codes
`define ERR_ACT_IGNORE        2'h0
`define ERR_ACT_SHUTDOWN      2'h1
`define ERR_ACT_DEV_RESET     2'h2

// voltage code to millivolts
`define MV_FINE_STEP          12'h032
`define MV_COARSE_STEP        12'h064
`define MV_COARSE_BASE        12'h6A4
`define MV_BASE_REG56         12'h384
`define MV_BASE_REG7          12'h3E8
`define KNEE_REG56            5'h0E
`define KNEE_REG7             5'h0C

`endif

// >>> pkg/ldo_regs_pkg.sv
/*
  Types shared by the regulator control bank and its test bench.
  Assumes nothing of its surroundings.
*/
package ldo_regs_pkg;

  // operating mode delivered to an analog regulator
  typedef enum logic [1:0] {
    PM_NORMAL     = 2'b00,
    PM_LP_REDUCED = 2'b01,
    PM_LP_MINIMUM = 2'b10,
    PM_OFF        = 2'b11
  } power_mode_type;

  typedef logic [15:0] ctrl_word_type;

endpackage

// >>> hdl/slot_decoder.sv
/*
  Combinational decode of one regulator's startup and sleep timeslot codes
  into one-hot timeslot selections and hardware enable assignment.
  Assumes the caller registers the results before they leave the block.
*/
`timescale 1ns/1ps
`default_nettype none

module slot_decoder
(
  input  wire logic [2:0] startup_slot_in,
  input  wire logic [2:0] sleep_slot_in,
  output logic      [4:0] enable_slot_out,
  output logic      [1:0] hw_enable_sel_out,
  output logic      [4:0] sleep_slot_out,
  output logic            sleep_disable_out
);
  logic hw_assigned;

  always_comb
  begin
    hw_assigned       = startup_slot_in[2] & startup_slot_in[1];
    enable_slot_out   = 5'h00;
    hw_enable_sel_out = 2'h0;
    // bit n-1 stands for timeslot n
    case (startup_slot_in)
      3'h0:    enable_slot_out = 5'h00;
      3'h6:    hw_enable_sel_out = 2'h1;
      3'h7:    hw_enable_sel_out = 2'h2;
      default: enable_slot_out = 5'(5'h01 << (startup_slot_in - 3'h1));
    endcase
  end

  always_comb
  begin
    sleep_slot_out    = 5'h00;
    sleep_disable_out = 1'b0;
    case (sleep_slot_in)
      3'h0:    sleep_slot_out = 5'h10;
      3'h6:    sleep_slot_out = 5'h04;
      3'h7:    sleep_slot_out = 5'h01;
      default:
      begin
        // higher code, earlier slot; same slot whether disabling or entering sleep
        sleep_slot_out    = 5'(5'h10 >> (sleep_slot_in - 3'h1));
        sleep_disable_out = ~hw_assigned;
      end
    endcase
  end

endmodule

`default_nettype wire

// >>> hdl/ldo_regulator_control_regs.sv
/*
  Control register bank for linear regulators five to seven, reached over
  APB, with undervoltage interrupt and error-action logic.
  Assumes an APB master on sys_clk_in, synchronous hardware control and
  undervoltage inputs, and an outside timeslot sequencer reading the
  decoded slot outputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"

module ldo_regulator_control_regs
(
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [31:0]                  paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  input  wire logic                         hw_ctrl1_in,
  input  wire logic                         hw_ctrl2_in,
  input  wire logic [2:0]                   undervoltage_in,
  output logic                              irq_out,
  output logic                              device_reset_out,
  output logic                              reg6_shutdown_out,
  output logic                              reg7_shutdown_out,
  output logic      [4:0]                   reg5_enable_slot_out,
  output logic      [1:0]                   reg5_hw_enable_sel_out,
  output logic      [4:0]                   reg5_sleep_slot_out,
  output logic                              reg5_sleep_disable_out,
  output ldo_regs_pkg::power_mode_type      reg5_active_mode_out,
  output ldo_regs_pkg::power_mode_type      reg5_sleep_mode_out,
  output logic      [11:0]                  reg5_active_mv_out,
  output logic      [11:0]                  reg5_sleep_mv_out,
  output logic      [4:0]                   reg6_enable_slot_out,
  output logic      [1:0]                   reg6_hw_enable_sel_out,
  output logic      [4:0]                   reg6_sleep_slot_out,
  output logic                              reg6_sleep_disable_out,
  output ldo_regs_pkg::power_mode_type      reg6_active_mode_out,
  output ldo_regs_pkg::power_mode_type      reg6_sleep_mode_out,
  output logic      [11:0]                  reg6_active_mv_out,
  output logic      [11:0]                  reg6_sleep_mv_out,
  output logic                              reg6_hw_active_out,
  output ldo_regs_pkg::power_mode_type      reg6_hw_mode_out,
  output logic      [11:0]                  reg6_hw_mv_out,
  output logic                              reg6_float_out,
  output logic                              reg6_switch_out,
  output logic      [4:0]                   reg7_enable_slot_out,
  output logic      [1:0]                   reg7_hw_enable_sel_out,
  output ldo_regs_pkg::power_mode_type      reg7_active_mode_out,
  output logic      [11:0]                  reg7_active_mv_out,
  output logic                              reg7_hw_active_out,
  output ldo_regs_pkg::power_mode_type      reg7_hw_mode_out,
  output logic                              reg7_hw_voltage_pick_out,
  output logic                              reg7_float_out,
  output logic                              reg7_switch_out
);
  import ldo_regs_pkg::*;

  localparam ctrl_word_type CTRL_MASK [`CTRL_COUNT] = '{
    `MASK_ONSLEEP_CTRL, `MASK_ONSLEEP_CTRL, `MASK_REG6_MAIN, `MASK_ONSLEEP_CTRL,
    `MASK_ONSLEEP_CTRL, `MASK_REG7_MAIN, `MASK_ONSLEEP_CTRL};
  localparam ctrl_word_type CTRL_RESET [`CTRL_COUNT] = '{
    `RESET_ON_CTRL, `RESET_SLEEP_CTRL, `RESET_MAIN_CTRL, `RESET_ON_CTRL,
    `RESET_SLEEP_CTRL, `RESET_MAIN_CTRL, `RESET_ON_CTRL};

  ctrl_word_type ctrl_reg [`CTRL_COUNT];
  logic [2:0]    irq_status_reg;
  logic [2:0]    irq_status_next;
  logic [2:0]    irq_enable_reg;
  logic [2:0]    irq_clear;

  logic          setup_phase;
  logic          access_write;
  logic          addr_is_ctrl;
  logic [2:0]    addr_slot;
  logic          addr_hit;
  logic [15:0]   addr_index;
  logic [31:0]   read_word;

  logic [4:0]    r5_en_slot;
  logic [1:0]    r5_hw_sel;
  logic [4:0]    r5_slp_slot;
  logic          r5_slp_dis;
  logic [4:0]    r6_en_slot;
  logic [1:0]    r6_hw_sel;
  logic [4:0]    r6_slp_slot;
  logic          r6_slp_dis;
  logic [4:0]    r7_en_slot;
  logic [1:0]    r7_hw_sel;

  ctrl_word_type r5_on;
  ctrl_word_type r5_slp;
  ctrl_word_type r6_main;
  ctrl_word_type r6_on;
  ctrl_word_type r6_slp;
  ctrl_word_type r7_main;
  ctrl_word_type r7_on;

  assign r5_on   = ctrl_reg[`SLOT_REG5_ON];
  assign r5_slp  = ctrl_reg[`SLOT_REG5_SLEEP];
  assign r6_main = ctrl_reg[`SLOT_REG6_MAIN];
  assign r6_on   = ctrl_reg[`SLOT_REG6_ON];
  assign r6_slp  = ctrl_reg[`SLOT_REG6_SLEEP];
  assign r7_main = ctrl_reg[`SLOT_REG7_MAIN];
  assign r7_on   = ctrl_reg[`SLOT_REG7_ON];

  function automatic logic [11:0] code_to_mv
  (
    input logic [4:0]  code,
    input logic [4:0]  knee,
    input logic [11:0] base
  );
    logic [4:0] coarse_steps;
    coarse_steps = 5'(code - knee - 5'h01);
    if (code <= knee)
      code_to_mv = 12'(base + 12'(code) * `MV_FINE_STEP);
    else
      code_to_mv = 12'(`MV_COARSE_BASE + 12'(coarse_steps) * `MV_COARSE_STEP);
  endfunction

  // low-power flavour picked by the variant bit where the regulator has one
  function automatic power_mode_type lp_mode(input logic lp_bit, input logic variant);
    if (!lp_bit)
      lp_mode = PM_NORMAL;
    else if (variant)
      lp_mode = PM_LP_MINIMUM;
    else
      lp_mode = PM_LP_REDUCED;
  endfunction

  function automatic power_mode_type hw_mode
  (
    input logic [1:0] code,
    input logic       on_bit,
    input logic       variant
  );
    case (code)
      2'h1:    hw_mode = PM_OFF;
      2'h3:    hw_mode = lp_mode(on_bit, variant);
      default: hw_mode = lp_mode(1'b1, variant);
    endcase
  endfunction

  // bus decode: only word-aligned addresses in the upper bits' zero page hit
  always_comb
  begin
    addr_index   = paddr_in[17:2];
    addr_is_ctrl = 1'b1;
    addr_slot    = 3'h0;
    case (addr_index)
      `IDX_REG5_ON_CTRL:    addr_slot = `SLOT_REG5_ON;
      `IDX_REG5_SLEEP_CTRL: addr_slot = `SLOT_REG5_SLEEP;
      `IDX_REG6_MAIN_CTRL:  addr_slot = `SLOT_REG6_MAIN;
      `IDX_REG6_ON_CTRL:    addr_slot = `SLOT_REG6_ON;
      `IDX_REG6_SLEEP_CTRL: addr_slot = `SLOT_REG6_SLEEP;
      `IDX_REG7_MAIN_CTRL:  addr_slot = `SLOT_REG7_MAIN;
      `IDX_REG7_ON_CTRL:    addr_slot = `SLOT_REG7_ON;
      default:              addr_is_ctrl = 1'b0;
    endcase
    addr_hit = (paddr_in[31:18] == 14'h0000) && (paddr_in[1:0] == 2'h0) &&
               (addr_is_ctrl || addr_index == `IDX_IRQ_STATUS ||
                addr_index == `IDX_IRQ_CLEAR || addr_index == `IDX_IRQ_ENABLE);
  end

  assign setup_phase  = psel_in & ~penable_in;
  assign access_write = psel_in & penable_in & pwrite_in & pready_out & addr_hit;

  always_comb
  begin
    read_word = 32'h0000_0000;
    if (addr_is_ctrl)
      read_word = {16'h0000, ctrl_reg[addr_slot]};
    else if (addr_index == `IDX_IRQ_STATUS)
      read_word = {29'h0000_0000, irq_status_reg};
    else if (addr_index == `IDX_IRQ_ENABLE)
      read_word = {29'h0000_0000, irq_enable_reg};
  end

  // no wait state: answer staged in setup, presented through the access cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= setup_phase;
      pslverr_out <= setup_phase & ~addr_hit;
      prdata_out  <= (setup_phase & ~pwrite_in & addr_hit) ? read_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < `CTRL_COUNT; i++)
        ctrl_reg[i] <= CTRL_RESET[i];
    end
    else if (access_write && addr_is_ctrl)
      ctrl_reg[addr_slot] <= pwdata_in[15:0] & CTRL_MASK[addr_slot];
  end

  // interrupt: sticky status, set beats clear in the same cycle
  always_comb
  begin
    irq_clear = 3'h0;
    if (access_write && addr_index == `IDX_IRQ_CLEAR)
      irq_clear = pwdata_in[2:0];
    irq_status_next = (irq_status_reg & ~irq_clear) | undervoltage_in;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_status_reg <= `RESET_IRQ;
      irq_enable_reg <= `RESET_IRQ;
      irq_out        <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      if (access_write && addr_index == `IDX_IRQ_ENABLE)
        irq_enable_reg <= pwdata_in[2:0];
      irq_out <= |(irq_status_next & irq_enable_reg);
    end
  end

  // error action: reserved code 11 acts as ignore
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      reg6_shutdown_out <= 1'b0;
      reg7_shutdown_out <= 1'b0;
      device_reset_out  <= 1'b0;
    end
    else
    begin
      reg6_shutdown_out <= undervoltage_in[1] &&
        r6_main[`FLD_ERR_ACT_HI:`FLD_ERR_ACT_LO] == `ERR_ACT_SHUTDOWN;
      reg7_shutdown_out <= undervoltage_in[2] &&
        r7_main[`FLD_ERR_ACT_HI:`FLD_ERR_ACT_LO] == `ERR_ACT_SHUTDOWN;
      device_reset_out  <=
        (undervoltage_in[1] &&
         r6_main[`FLD_ERR_ACT_HI:`FLD_ERR_ACT_LO] == `ERR_ACT_DEV_RESET) ||
        (undervoltage_in[2] &&
         r7_main[`FLD_ERR_ACT_HI:`FLD_ERR_ACT_LO] == `ERR_ACT_DEV_RESET);
    end
  end

  slot_decoder u_reg5_slots
  (
    .startup_slot_in   (r5_on[`FLD_SLOT_HI:`FLD_SLOT_LO]),
    .sleep_slot_in     (r5_slp[`FLD_SLOT_HI:`FLD_SLOT_LO]),
    .enable_slot_out   (r5_en_slot),
    .hw_enable_sel_out (r5_hw_sel),
    .sleep_slot_out    (r5_slp_slot),
    .sleep_disable_out (r5_slp_dis)
  );

  slot_decoder u_reg6_slots
  (
    .startup_slot_in   (r6_on[`FLD_SLOT_HI:`FLD_SLOT_LO]),
    .sleep_slot_in     (r6_slp[`FLD_SLOT_HI:`FLD_SLOT_LO]),
    .enable_slot_out   (r6_en_slot),
    .hw_enable_sel_out (r6_hw_sel),
    .sleep_slot_out    (r6_slp_slot),
    .sleep_disable_out (r6_slp_dis)
  );

  // seven's sleep register lives outside this bank
  slot_decoder u_reg7_slots
  (
    .startup_slot_in   (r7_on[`FLD_SLOT_HI:`FLD_SLOT_LO]),
    .sleep_slot_in     (3'h0),
    .enable_slot_out   (r7_en_slot),
    .hw_enable_sel_out (r7_hw_sel),
    .sleep_slot_out    (),
    .sleep_disable_out ()
  );

  // timeslot selections to the sequencer
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      reg5_enable_slot_out   <= 5'h00;
      reg5_hw_enable_sel_out <= 2'h0;
      reg5_sleep_slot_out    <= 5'h00;
      reg5_sleep_disable_out <= 1'b0;
      reg6_enable_slot_out   <= 5'h00;
      reg6_hw_enable_sel_out <= 2'h0;
      reg6_sleep_slot_out    <= 5'h00;
      reg6_sleep_disable_out <= 1'b0;
      reg7_enable_slot_out   <= 5'h00;
      reg7_hw_enable_sel_out <= 2'h0;
    end
    else
    begin
      reg5_enable_slot_out   <= r5_en_slot;
      reg5_hw_enable_sel_out <= r5_hw_sel;
      reg5_sleep_slot_out    <= r5_slp_slot;
      reg5_sleep_disable_out <= r5_slp_dis;
      reg6_enable_slot_out   <= r6_en_slot;
      reg6_hw_enable_sel_out <= r6_hw_sel;
      reg6_sleep_slot_out    <= r6_slp_slot;
      reg6_sleep_disable_out <= r6_slp_dis;
      reg7_enable_slot_out   <= r7_en_slot;
      reg7_hw_enable_sel_out <= r7_hw_sel;
    end
  end

  // modes and voltages; five and seven have no variant bit here, so reduced
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      reg5_active_mode_out <= PM_NORMAL;
      reg5_sleep_mode_out  <= PM_LP_REDUCED;
      reg5_active_mv_out   <= `MV_BASE_REG56;
      reg5_sleep_mv_out    <= `MV_BASE_REG56;
      reg6_active_mode_out <= PM_NORMAL;
      reg6_sleep_mode_out  <= PM_LP_REDUCED;
      reg6_active_mv_out   <= `MV_BASE_REG56;
      reg6_sleep_mv_out    <= `MV_BASE_REG56;
      reg7_active_mode_out <= PM_NORMAL;
      reg7_active_mv_out   <= `MV_BASE_REG7;
    end
    else
    begin
      reg5_active_mode_out <= lp_mode(r5_on[`FLD_MODE], 1'b0);
      reg5_sleep_mode_out  <= lp_mode(r5_slp[`FLD_MODE], 1'b0);
      reg5_active_mv_out   <= code_to_mv(r5_on[`FLD_VCODE_HI:`FLD_VCODE_LO],
                                         `KNEE_REG56, `MV_BASE_REG56);
      reg5_sleep_mv_out    <= code_to_mv(r5_slp[`FLD_VCODE_HI:`FLD_VCODE_LO],
                                         `KNEE_REG56, `MV_BASE_REG56);
      reg6_active_mode_out <= lp_mode(r6_on[`FLD_MODE],
                                      r6_main[`FLD_LP_VARIANT]);
      reg6_sleep_mode_out  <= lp_mode(r6_slp[`FLD_MODE],
                                      r6_main[`FLD_LP_VARIANT]);
      reg6_active_mv_out   <= code_to_mv(r6_on[`FLD_VCODE_HI:`FLD_VCODE_LO],
                                         `KNEE_REG56, `MV_BASE_REG56);
      reg6_sleep_mv_out    <= code_to_mv(r6_slp[`FLD_VCODE_HI:`FLD_VCODE_LO],
                                         `KNEE_REG56, `MV_BASE_REG56);
      reg7_active_mode_out <= lp_mode(r7_on[`FLD_MODE], 1'b0);
      reg7_active_mv_out   <= code_to_mv(r7_on[`FLD_VCODE_HI:`FLD_VCODE_LO],
                                         `KNEE_REG7, `MV_BASE_REG7);
    end
  end

  // hardware control and output options
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      reg6_hw_active_out       <= 1'b0;
      reg6_hw_mode_out         <= PM_LP_REDUCED;
      reg6_hw_mv_out           <= `MV_BASE_REG56;
      reg6_float_out           <= 1'b0;
      reg6_switch_out          <= 1'b0;
      reg7_hw_active_out       <= 1'b0;
      reg7_hw_mode_out         <= PM_LP_REDUCED;
      reg7_hw_voltage_pick_out <= 1'b0;
      reg7_float_out           <= 1'b0;
      reg7_switch_out          <= 1'b0;
    end
    else
    begin
      reg6_hw_active_out <= (r6_main[`FLD_HW_SRC_LO] & hw_ctrl1_in) |
                            (r6_main[`FLD_HW_SRC_HI] & hw_ctrl2_in);
      reg6_hw_mode_out   <= hw_mode(r6_main[`FLD_HW_MODE_HI:`FLD_HW_MODE_LO],
                                    r6_on[`FLD_MODE],
                                    r6_main[`FLD_LP_VARIANT]);
      reg6_hw_mv_out     <= r6_main[`FLD_HW_VPICK] ?
        code_to_mv(r6_slp[`FLD_VCODE_HI:`FLD_VCODE_LO], `KNEE_REG56, `MV_BASE_REG56) :
        code_to_mv(r6_on[`FLD_VCODE_HI:`FLD_VCODE_LO], `KNEE_REG56, `MV_BASE_REG56);
      reg6_float_out     <= r6_main[`FLD_FLOAT];
      reg6_switch_out    <= r6_main[`FLD_SWITCH];
      reg7_hw_active_out <= (r7_main[`FLD_HW_SRC_LO] & hw_ctrl1_in) |
                            (r7_main[`FLD_HW_SRC_HI] & hw_ctrl2_in);
      reg7_hw_mode_out   <= hw_mode(r7_main[`FLD_HW_MODE_HI:`FLD_HW_MODE_LO],
                                    r7_on[`FLD_MODE], 1'b0);
      // sleep code sits outside; the pick goes out for the consumer to apply
      reg7_hw_voltage_pick_out <= r7_main[`FLD_HW_VPICK];
      reg7_float_out     <= r7_main[`FLD_FLOAT];
      reg7_switch_out    <= r7_main[`FLD_SWITCH];
    end
  end

endmodule

`default_nettype wire

// >>> verif/ldo_bank_monitor.sv
/* bus and event checker for the regulator bank; bound to its top module */
`timescale 1ns/1ps
`default_nettype none
module ldo_bank_monitor
(
  input wire logic       sys_clk_in, rst_n_in, psel_in, penable_in, hw_ctrl1_in, hw_ctrl2_in,
  input wire logic       pready_out, pslverr_out, irq_out, reg6_shutdown_out, device_reset_out,
  input wire logic       reg6_hw_active_out,
  input wire logic [2:0] undervoltage_in,
  input wire logic [4:0] reg5_enable_slot_out,
  input wire logic [1:0] reg5_hw_enable_sel_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready_out) else $error("ready late");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("ready held");
  a_error_with_ready: assert property (pslverr_out |-> pready_out) else $error("lone error");
  a_irq_stays_set: assert property (irq_out && !psel_in |=> irq_out) else $error("irq lost");
  a_slot_one_hot: assert property ($onehot0(reg5_enable_slot_out)) else $error("slot");
  a_hw_slot_excl: assert property (reg5_hw_enable_sel_out != 2'h0 |->
    reg5_enable_slot_out == 5'h00 && reg5_hw_enable_sel_out != 2'h3) else $error("hw sel");
  a_shutdown_cause: assert property (reg6_shutdown_out |-> $past(undervoltage_in[1]))
    else $error("shutdown without event");
  a_reset_cause: assert property (device_reset_out |-> $past(undervoltage_in[2:1]) != 2'h0)
    else $error("reset without event");
  a_hw_idle: assert property (!hw_ctrl1_in && !hw_ctrl2_in |=> !reg6_hw_active_out)
    else $error("hw active without input");
endmodule
bind ldo_regulator_control_regs ldo_bank_monitor mon_u (.*);
`default_nettype wire

// >>> verif/tb_top.sv
/* self-checking bench for the regulator bank; drives apb, hw and fault inputs */
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"
module tb_top;
  import ldo_regs_pkg::*;
  logic sys_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, er;
  logic hw_ctrl1_in, hw_ctrl2_in, irq_out, device_reset_out, reg6_shutdown_out, reg7_shutdown_out;
  logic reg5_sleep_disable_out, reg6_sleep_disable_out, reg6_hw_active_out, reg7_hw_active_out;
  logic reg6_float_out, reg6_switch_out, reg7_hw_voltage_pick_out, reg7_float_out, reg7_switch_out;
  logic [31:0] paddr_in, pwdata_in, prdata_out, rd;
  logic [2:0]  undervoltage_in;
  logic [4:0]  reg5_enable_slot_out, reg5_sleep_slot_out, reg6_enable_slot_out;
  logic [4:0]  reg6_sleep_slot_out, reg7_enable_slot_out;
  logic [1:0]  reg5_hw_enable_sel_out, reg6_hw_enable_sel_out, reg7_hw_enable_sel_out;
  power_mode_type reg5_active_mode_out, reg5_sleep_mode_out, reg6_active_mode_out;
  power_mode_type reg6_sleep_mode_out, reg6_hw_mode_out, reg7_active_mode_out, reg7_hw_mode_out;
  logic [11:0] reg5_active_mv_out, reg5_sleep_mv_out, reg6_active_mv_out, reg6_sleep_mv_out;
  logic [11:0] reg6_hw_mv_out, reg7_active_mv_out;
  int          err_total, check_count;
  ldo_regulator_control_regs dut_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] ix, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= {14'h0, ix, 2'h0};
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    n = 0;
    // pready, data and error are taken at the very edge that sees pready high
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 8);
    if (pready_out !== 1'b1)
    begin
      err_total++;
      conclude();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic uv_pulse(input logic [2:0] v);
    @(posedge sys_clk_in) undervoltage_in <= v;
    @(posedge sys_clk_in) undervoltage_in <= 3'h0;
    @(negedge sys_clk_in);
  endtask
  // derived outputs lag the register by one more clock
  task automatic wrs(input logic [15:0] ix, input logic [31:0] d);
    apb(1'b1, ix, d);
    repeat (2) @(negedge sys_clk_in);
  endtask
  task automatic s_regs;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 16'h4075 + i, 32'h0);
      chk(rd, (i == 1 || i == 4) ? 32'h100 : (i == 2 || i == 5) ? 32'h200 : 32'h0);
      apb(1'b1, 16'h4075 + i, 32'hFFFFFFFF);
      apb(1'b0, 16'h4075 + i, 32'h0);
      chk(rd, i == 2 ? 32'hDFC1 : i == 5 ? 32'hDFC0 : 32'hE11F);
    end
    apb(1'b0, 16'h0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic s_slots;
    for (int c = 0; c < 8; c++)
    begin
      wrs(16'h4075, c << 13);
      chk(reg5_enable_slot_out, (c > 0 && c < 6) ? 1 << (c - 1) : 0);
      chk(reg5_hw_enable_sel_out, c == 6 ? 1 : c == 7 ? 2 : 0);
    end
    for (int h = 0; h < 2; h++)
      for (int c = 0; c < 8; c++)
      begin
        apb(1'b1, 16'h4075, h * 32'hC000);
        wrs(16'h4076, c << 13);
        chk(reg5_sleep_slot_out, c == 0 ? 16 : c == 6 ? 4 : c == 7 ? 1 : 1 << (5 - c));
        chk(reg5_sleep_disable_out, c > 0 && c < 6 && h == 0);
        chk({reg5_sleep_mode_out, reg5_sleep_mv_out}, {PM_NORMAL, 12'h384});
      end
  endtask
  task automatic s_volt;
    for (int c = 0; c < 32; c++)
    begin
      apb(1'b1, 16'h4075, c | ((c & 1) << 8));
      wrs(16'h407B, c);
      chk(reg5_active_mv_out, c < 15 ? 900 + 50 * c : 1700 + 100 * (c - 15));
      chk(reg7_active_mv_out, c < 13 ? 1000 + 50 * c : 1700 + 100 * (c - 13));
      chk(reg5_active_mode_out, (c & 1) ? PM_LP_REDUCED : PM_NORMAL);
    end
  endtask
  // regulator six: on code 3, sleep code 11h in low power, variant bit set
  task automatic s_hw;
    power_mode_type hw_exp;
    apb(1'b1, 16'h4078, 32'h0003);
    apb(1'b1, 16'h4079, 32'h0111);
    apb(1'b1, 16'h407B, 32'h0000);
    for (int m = 0; m < 4; m++)
    begin
      wrs(16'h4077, (m << 8) | (m << 6) | ((m & 1) << 10) | 1);
      wrs(16'h407A, (m << 8) | (m << 6) | ((m & 1) << 10));
      hw_exp = m == 1 ? PM_OFF : m == 3 ? PM_NORMAL : PM_LP_MINIMUM;
      chk(reg6_hw_mode_out, hw_exp);
      chk(reg7_hw_mode_out, m[0] ? hw_exp : PM_LP_REDUCED);
      chk(reg6_hw_mv_out, (m & 1) ? 1900 : 1050);
      chk(reg7_hw_voltage_pick_out, m & 1);
      chk({reg6_float_out, reg6_switch_out, reg7_float_out, reg7_switch_out}, m * 5);
    end
    chk({reg6_active_mode_out, reg6_sleep_mode_out}, {PM_NORMAL, PM_LP_MINIMUM});
    chk(reg6_active_mv_out, 1050);
    chk(reg6_sleep_mv_out, 1900);
  endtask
  task automatic s_fault;
    apb(1'b1, `IDX_IRQ_ENABLE, 32'h7);
    for (int a = 0; a < 3; a++)
    begin
      wrs(16'h4077, (a << 14) | 32'h0800);
      uv_pulse(3'h2);
      chk({irq_out, reg6_shutdown_out, device_reset_out}, {1'b1, a == 1, a == 2});
      apb(1'b1, `IDX_IRQ_CLEAR, 32'h2);
      apb(1'b0, `IDX_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0);
      hw_ctrl1_in <= a[0];
      hw_ctrl2_in <= a[1];
      repeat (2) @(negedge sys_clk_in);
      chk(reg6_hw_active_out, a == 1);
    end
    wrs(16'h407A, 32'h4000);
    uv_pulse(3'h4);
    chk({irq_out, reg7_shutdown_out, device_reset_out}, 3'h6);
    apb(1'b0, `IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h4);
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    {rst_n_in, psel_in, penable_in, pwrite_in, hw_ctrl1_in, hw_ctrl2_in} = 6'h0;
    {paddr_in, pwdata_in, undervoltage_in} = 67'h0;
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    s_regs();
    s_slots();
    s_volt();
    s_hw();
    s_fault();
    conclude();
  end
endmodule
`default_nettype wire
